/* File: logic/wor_map.vh */
// Constants for the write-once system option register block.
// Assumes an 8-bit register port with 16-bit byte addresses.
`ifndef WOR_MAP_VH
`define WOR_MAP_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define WOR_ADDR_SECONDARY 16'h001e
`define WOR_ADDR_PRIMARY 16'h001f
`define WOR_ADDR_STATUS 16'h0020

// ****************************************************************
// Field positions, primary options
// ****************************************************************
`define WOR_P_PERIOD_SELECT 7
`define WOR_P_UV_STOP_ENABLE 6
`define WOR_P_UV_RESET_DISABLE 5
`define WOR_P_UV_POWER_DISABLE 4
`define WOR_P_TRIP_LEVEL_SELECT 3
`define WOR_P_SHORT_RECOVERY 2
`define WOR_P_STOP_ENABLE 1
`define WOR_P_WATCHDOG_DISABLE 0

// ****************************************************************
// Field positions, secondary options
// ****************************************************************
`define WOR_S_IRQ_PULLUP_DISABLE 7
`define WOR_S_IRQ_FUNCTION_ENABLE 6
`define WOR_S_OSC_SOURCE_BIT1 4
`define WOR_S_OSC_SOURCE_BIT0 3
`define WOR_S_RESET_PIN_ENABLE 0

// Bits that stay writable after the lock, primary register
`define WOR_P_ALWAYS_MASK 8'h28
// Bits implemented in the secondary register
`define WOR_S_USED_MASK 8'hd9

// ****************************************************************
// Reset values
// ****************************************************************
`define WOR_PRIMARY_RESET 8'h00
`define WOR_SECONDARY_RESET 8'h00
`define WOR_READ_IDLE 8'h00

// ****************************************************************
// Oscillator source codes
// ****************************************************************
`define WOR_OSC_INTERNAL 2'b00
`define WOR_OSC_EXT_CLOCK 2'b01
`define WOR_OSC_EXT_RC 2'b10
`define WOR_OSC_EXT_XTAL 2'b11

// ****************************************************************
// Timing counts in oscillator cycles
// ****************************************************************
`define WOR_WDOG_SHORT 19'h01ff0
`define WOR_WDOG_LONG 19'h3fff0
`define WOR_WAKE_SHORT 15'h0200
`define WOR_WAKE_LONG 15'h4000
`define WOR_RECOVERY_SHORT 13'h0020
`define WOR_RECOVERY_LONG 13'h1000

`endif

/* File: logic/wor_option_regs.v */
// Write-once system option registers with decoded option outputs.
// Assumes clk_sys_i is the oscillator clock, reset_i is raised by every
// reset source and por_reset_i only by power-on reset.
// stop_exit_uv_i is read together with stop_exit_i; monitor_trip_i is
// asynchronous and is synchronised here before use.
//
// Summary of operation
// - Only first write per register after reset is taken whole; later ones change only the bits below.
// - Trip level and undervoltage reset disable bits are always writable.
// - Registers sit at two consecutive byte addresses, always readable.
// - Any reset clears option bits except those kept over non-power-on reset.
// - Reset pin enable bit is cleared by power-on reset only.
// - Trip level select bit is cleared by power-on reset only.
// - Pullup disable bit one disconnects the interrupt pin pullup.
// - Interrupt function bit one activates the interrupt pin function.
// - Oscillator field: 00 internal, 01 clock, 10 RC, 11 crystal.
// - Reset pin bit one activates the reset pin function.
// - Outside stop, period select picks watchdog timeout length.
// - In stop, period select picks the auto wakeup period.
// - Stop enable keeps monitor running in stop unless powered down.
// - Reset disable bit one blocks monitor resets.
// - Power disable bit one powers down the undervoltage monitor.
// - Trip select one picks warning level, zero picks reset level.
// - Short recovery bit selects 32 rather than 4096 cycle stop exit.
// - Stop exit by monitor reset always uses the long delay.
// - Stop enable zero makes the stop instruction an illegal opcode.
// - Watchdog disable bit one turns the watchdog off.
`timescale 1ns/10ps
`include "wor_map.vh"

module wor_option_regs
(
   input wire clk_sys_i,
   input wire reset_i,
   input wire por_reset_i,
   // Register port
   input wire [15:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_write_i,
   input wire reg_read_i,
   output reg [7:0] reg_rdata_o,
   // Core status
   input wire stop_mode_i,
   input wire stop_request_i,
   input wire stop_exit_i,
   input wire stop_exit_uv_i,
   input wire monitor_trip_i,
   // Option outputs
   output wire irq_pullup_enable_o,
   output wire irq_function_enable_o,
   output wire osc_internal_o,
   output wire osc_ext_clock_o,
   output wire osc_ext_rc_o,
   output wire osc_ext_xtal_o,
   output wire reset_pin_function_enable_o,
   output wire [18:0] watchdog_timeout_o,
   output wire [14:0] wakeup_period_o,
   output wire watchdog_enable_o,
   output wire monitor_power_enable_o,
   output wire monitor_stop_active_o,
   output wire trip_level_select_o,
   output reg undervoltage_reset_o,
   output wire stop_legal_o,
   output reg stop_illegal_o,
   output wire recovery_busy_o,
   output reg recovery_done_o
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   reg [7:0] primary_reset_bits;
   reg [7:0] secondary_reset_bits;
   reg trip_level_select;
   reg reset_pin_function_enable;
   reg primary_locked;
   reg secondary_locked;
   reg trip_meta;
   reg trip_sync;
   reg [12:0] recovery_count;
   reg recovery_active;
   wire [7:0] system_options_primary;
   wire [7:0] system_options_secondary;
   wire wr_primary;
   wire wr_secondary;
   wire [12:0] recovery_length;
   reg [7:0] next_primary;
   reg [7:0] next_secondary;
   reg [7:0] next_rdata;
   wire [1:0] osc_source;

   // Address decode for writes
   assign wr_primary = reg_write_i & (reg_addr_i == `WOR_ADDR_PRIMARY);
   assign wr_secondary = reg_write_i & (reg_addr_i == `WOR_ADDR_SECONDARY);

   // Assemble register images from reset-class storage
   assign system_options_primary =
      {primary_reset_bits[7:4], trip_level_select, primary_reset_bits[2:0]};
   assign system_options_secondary =
      {secondary_reset_bits[7:1], reset_pin_function_enable};

   // ****************************************************************
   // Write-once lock flags
   // ****************************************************************
   // lock on write
   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         primary_locked <= 1'b0;
         secondary_locked <= 1'b0;
      end
      else
      begin
         if (wr_primary)
            primary_locked <= 1'b1;
         if (wr_secondary)
            secondary_locked <= 1'b1;
      end
   end

   // ****************************************************************
   // Write merge under the lock
   // ****************************************************************
   // lock write merge
   always @*
   begin
      next_primary = primary_reset_bits;
      next_secondary = secondary_reset_bits;
      if (wr_primary)
      begin
         if (primary_locked)
            next_primary = (primary_reset_bits & ~`WOR_P_ALWAYS_MASK) |
               (reg_wdata_i & `WOR_P_ALWAYS_MASK);
         else
            next_primary = reg_wdata_i;
      end
      if (wr_secondary && !secondary_locked)
         next_secondary = reg_wdata_i & `WOR_S_USED_MASK;
   end

   // ****************************************************************
   // Bits cleared by every reset
   // ****************************************************************
   // clear on reset
   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         primary_reset_bits <= `WOR_PRIMARY_RESET;
         secondary_reset_bits <= `WOR_SECONDARY_RESET;
      end
      else
      begin
         primary_reset_bits <= next_primary;
         secondary_reset_bits <= next_secondary;
      end
   end

   // ****************************************************************
   // Bits cleared only by power-on reset
   // ****************************************************************
   // power-on clear only
   always @(posedge clk_sys_i or posedge por_reset_i)
   begin
      if (por_reset_i)
         trip_level_select <= 1'b0;
      else if (wr_primary)
         trip_level_select <= reg_wdata_i[`WOR_P_TRIP_LEVEL_SELECT];
   end

   always @(posedge clk_sys_i or posedge por_reset_i)
   begin
      if (por_reset_i)
         reset_pin_function_enable <= 1'b0;
      // write-once, lock cleared by any reset
      else if (wr_secondary && !secondary_locked)
         reset_pin_function_enable <=
            reg_wdata_i[`WOR_S_RESET_PIN_ENABLE];
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   // read any time
   always @*
   begin
      case (reg_addr_i)
         `WOR_ADDR_PRIMARY: next_rdata = system_options_primary;
         `WOR_ADDR_SECONDARY: next_rdata = system_options_secondary;
         `WOR_ADDR_STATUS:
            next_rdata = {5'h00, recovery_active, secondary_locked,
               primary_locked};
         default: next_rdata = `WOR_READ_IDLE;
      endcase
   end

   // Read data stand one cycle after the strobe, idle otherwise
   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         reg_rdata_o <= `WOR_READ_IDLE;
      else if (reg_read_i)
         reg_rdata_o <= next_rdata;
      else
         reg_rdata_o <= `WOR_READ_IDLE;
   end

   // ****************************************************************
   // Interrupt pin, oscillator and reset pin options
   // ****************************************************************
   // pullup control
   assign irq_pullup_enable_o =
      ~system_options_secondary[`WOR_S_IRQ_PULLUP_DISABLE];
   assign irq_function_enable_o =
      system_options_secondary[`WOR_S_IRQ_FUNCTION_ENABLE];
   // Oscillator source field gathered from its two bit positions
   assign osc_source = {system_options_secondary[`WOR_S_OSC_SOURCE_BIT1],
      system_options_secondary[`WOR_S_OSC_SOURCE_BIT0]};
   wor_code_match #(.MATCH_CODE(`WOR_OSC_INTERNAL)) match_internal
   (
      .code_i(osc_source),
      .match_o(osc_internal_o)
   );
   wor_code_match #(.MATCH_CODE(`WOR_OSC_EXT_CLOCK)) match_ext_clock
   (
      .code_i(osc_source),
      .match_o(osc_ext_clock_o)
   );
   wor_code_match #(.MATCH_CODE(`WOR_OSC_EXT_RC)) match_ext_rc
   (
      .code_i(osc_source),
      .match_o(osc_ext_rc_o)
   );
   wor_code_match #(.MATCH_CODE(`WOR_OSC_EXT_XTAL)) match_ext_xtal
   (
      .code_i(osc_source),
      .match_o(osc_ext_xtal_o)
   );
   assign reset_pin_function_enable_o = reset_pin_function_enable;

   // ****************************************************************
   // Watchdog and wakeup periods
   // ****************************************************************
   // watchdog timeout
   assign watchdog_timeout_o =
      system_options_primary[`WOR_P_PERIOD_SELECT] ?
      `WOR_WDOG_SHORT : `WOR_WDOG_LONG;
   assign wakeup_period_o =
      system_options_primary[`WOR_P_PERIOD_SELECT] ?
      `WOR_WAKE_SHORT : `WOR_WAKE_LONG;
   assign watchdog_enable_o =
      ~system_options_primary[`WOR_P_WATCHDOG_DISABLE];

   // ****************************************************************
   // Undervoltage monitor control
   // ****************************************************************
   // monitor power
   assign monitor_power_enable_o =
      ~system_options_primary[`WOR_P_UV_POWER_DISABLE];
   assign monitor_stop_active_o = monitor_power_enable_o & stop_mode_i &
      system_options_primary[`WOR_P_UV_STOP_ENABLE];
   assign trip_level_select_o = trip_level_select;

   // Trip input comes from the analog monitor, synchronise it
   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         trip_meta <= 1'b0;
         trip_sync <= 1'b0;
      end
      else
      begin
         trip_meta <= monitor_trip_i;
         trip_sync <= trip_meta;
      end
   end

   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         undervoltage_reset_o <= 1'b0;
      else
         undervoltage_reset_o <= trip_sync & monitor_power_enable_o &
            ~system_options_primary[`WOR_P_UV_RESET_DISABLE];
   end

   // ****************************************************************
   // Stop instruction legality
   // ****************************************************************
   // stop enable
   assign stop_legal_o = system_options_primary[`WOR_P_STOP_ENABLE];

   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         stop_illegal_o <= 1'b0;
      else
         stop_illegal_o <= stop_request_i & ~stop_legal_o;
   end

   // ****************************************************************
   // Stop recovery delay
   // ****************************************************************
   // recovery length choice
   assign recovery_length =
      (system_options_primary[`WOR_P_SHORT_RECOVERY] && !stop_exit_uv_i) ?
      `WOR_RECOVERY_SHORT : `WOR_RECOVERY_LONG;
   assign recovery_busy_o = recovery_active;

   // Counts down the delay and pulses done at its end
   always @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         recovery_active <= 1'b0;
         recovery_count <= 13'h0000;
         recovery_done_o <= 1'b0;
      end
      else
      begin
         recovery_done_o <= 1'b0;
         if (stop_exit_i && !recovery_active)
         begin
            recovery_active <= 1'b1;
            recovery_count <= recovery_length - 13'h0001;
         end
         else if (recovery_active)
         begin
            if (recovery_count == 13'h0000)
            begin
               recovery_active <= 1'b0;
               recovery_done_o <= 1'b1;
            end
            else
               recovery_count <= recovery_count - 13'h0001;
         end
      end
   end

endmodule // wor_option_regs

// ****************************************************************
// Two-bit code comparator, one per decoded option value
// ****************************************************************
module wor_code_match
#(
   parameter [1:0] MATCH_CODE = 2'b00
)
(
   input wire [1:0] code_i,
   output wire match_o
);

   // High while the field holds this instance's code
   assign match_o = (code_i == MATCH_CODE);

endmodule // wor_code_match

/* File: dv/wor_option_regs_sva.sv */
// Checker for the write-once option register block.
// Assumes it is bound into wor_option_regs, one clock domain.
`timescale 1ns/10ps
`include "wor_map.vh"
module wor_option_regs_sva
(
   input wire clk_sys_i,
   input wire reset_i,
   input wire [15:0] reg_addr_i,
   input wire reg_read_i,
   input wire [7:0] reg_rdata_o,
   input wire stop_request_i,
   input wire stop_exit_i,
   input wire stop_exit_uv_i,
   input wire irq_pullup_enable_o,
   input wire [18:0] watchdog_timeout_o,
   input wire [14:0] wakeup_period_o,
   input wire watchdog_enable_o,
   input wire stop_legal_o,
   input wire stop_illegal_o,
   input wire recovery_busy_o,
   input wire recovery_done_o
);
   // ********************
   // Recovery length helper
   // ********************
   reg [12:0] cnt;
   reg long_f;
   wire start = stop_exit_i && !recovery_busy_o;
   wire rd_p = reg_read_i && reg_addr_i == `WOR_ADDR_PRIMARY;
   wire rd_s = reg_read_i && reg_addr_i == `WOR_ADDR_SECONDARY;
   // Counts cycles since the accepted exit
   always @(posedge clk_sys_i or posedge reset_i)
      if (reset_i)
         cnt <= 13'h0000;
      else if (start)
         cnt <= 13'h0000;
      else if (recovery_busy_o)
         cnt <= cnt + 13'h0001;
   // Remembers whether the exit came from the monitor
   always @(posedge clk_sys_i or posedge reset_i)
      if (reset_i)
         long_f <= 1'b0;
      else if (start)
         long_f <= stop_exit_uv_i;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // ********************
   // Assertions
   // ********************
   a_rdata_idle:
   assert property (!reg_read_i |=> reg_rdata_o == `WOR_READ_IDLE)
      else $error("read data not idle");
   a_stop_illegal:
   assert property (stop_request_i |=> stop_illegal_o == !$past(stop_legal_o))
      else $error("illegal stop flag wrong");
   a_stop_readback:
   assert property (rd_p |=> reg_rdata_o[1] == $past(stop_legal_o))
      else $error("stop enable differs from register");
   a_pullup_bit:
   assert property (rd_s |=> reg_rdata_o[7] != $past(irq_pullup_enable_o))
      else $error("pullup differs from register");
   a_watchdog_bit:
   assert property (rd_p |=> reg_rdata_o[0] != $past(watchdog_enable_o))
      else $error("watchdog enable differs from register");
   a_watchdog_period:
   assert property (rd_p |=> $past(watchdog_timeout_o) ==
      (reg_rdata_o[7] ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG))
      else $error("watchdog timeout wrong");
   a_wakeup_period:
   assert property (wakeup_period_o == (watchdog_timeout_o ==
      `WOR_WDOG_SHORT ? `WOR_WAKE_SHORT : `WOR_WAKE_LONG))
      else $error("wakeup period wrong");
   a_recovery_start:
   assert property (start |=> recovery_busy_o [*2])
      else $error("recovery did not start");
   a_recovery_length:
   assert property (recovery_done_o |-> cnt == `WOR_RECOVERY_LONG ||
      (!long_f && cnt == `WOR_RECOVERY_SHORT))
      else $error("recovery length wrong");
   a_recovery_bound:
   assert property (cnt <= `WOR_RECOVERY_LONG)
      else $error("recovery overran");
   c_read_primary: cover property (rd_p);
   c_stop_illegal: cover property (stop_illegal_o);
   c_long_recovery: cover property (recovery_done_o && long_f);
endmodule // wor_option_regs_sva
bind wor_option_regs wor_option_regs_sva wor_option_regs_sva_inst
(
   .clk_sys_i(clk_sys_i),
   .reset_i(reset_i),
   .reg_addr_i(reg_addr_i),
   .reg_read_i(reg_read_i),
   .reg_rdata_o(reg_rdata_o),
   .stop_request_i(stop_request_i),
   .stop_exit_i(stop_exit_i),
   .stop_exit_uv_i(stop_exit_uv_i),
   .irq_pullup_enable_o(irq_pullup_enable_o),
   .watchdog_timeout_o(watchdog_timeout_o),
   .wakeup_period_o(wakeup_period_o),
   .watchdog_enable_o(watchdog_enable_o),
   .stop_legal_o(stop_legal_o),
   .stop_illegal_o(stop_illegal_o),
   .recovery_busy_o(recovery_busy_o),
   .recovery_done_o(recovery_done_o)
);

/* File: dv/tb.sv */
// Self-checking bench for the option register block.
// Assumes the design and its checker are compiled alongside.
`timescale 1ns/10ps
`include "wor_map.vh"
module tb;
   reg clk_sys_i = 1'b0;
   reg reset_i = 1'b1;
   reg por_reset_i = 1'b1;
   reg [15:0] reg_addr_i = 16'h0000;
   reg [7:0] reg_wdata_i = 8'h00;
   reg reg_write_i = 1'b0, reg_read_i = 1'b0, stop_mode_i = 1'b0;
   reg stop_request_i = 1'b0, stop_exit_i = 1'b0;
   reg stop_exit_uv_i = 1'b0, monitor_trip_i = 1'b0;
   wire [7:0] reg_rdata_o;
   wire [18:0] watchdog_timeout_o;
   wire [14:0] wakeup_period_o;
   wire irq_pullup_enable_o, irq_function_enable_o, osc_internal_o;
   wire osc_ext_clock_o, osc_ext_rc_o, osc_ext_xtal_o;
   wire reset_pin_function_enable_o, watchdog_enable_o;
   wire monitor_power_enable_o, monitor_stop_active_o;
   wire trip_level_select_o, undervoltage_reset_o, stop_legal_o;
   wire stop_illegal_o, recovery_busy_o, recovery_done_o;
   integer miscompares = 0, comparisons = 0, cycles = 0, i, n;
   reg [7:0] d;
   reg [31:0] rows [0:6];
   wor_option_regs wor_option_regs_inst
   (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .por_reset_i(por_reset_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o),
      .stop_mode_i(stop_mode_i),
      .stop_request_i(stop_request_i),
      .stop_exit_i(stop_exit_i),
      .stop_exit_uv_i(stop_exit_uv_i),
      .monitor_trip_i(monitor_trip_i),
      .irq_pullup_enable_o(irq_pullup_enable_o),
      .irq_function_enable_o(irq_function_enable_o),
      .osc_internal_o(osc_internal_o),
      .osc_ext_clock_o(osc_ext_clock_o),
      .osc_ext_rc_o(osc_ext_rc_o),
      .osc_ext_xtal_o(osc_ext_xtal_o),
      .reset_pin_function_enable_o(reset_pin_function_enable_o),
      .watchdog_timeout_o(watchdog_timeout_o),
      .wakeup_period_o(wakeup_period_o),
      .watchdog_enable_o(watchdog_enable_o),
      .monitor_power_enable_o(monitor_power_enable_o),
      .monitor_stop_active_o(monitor_stop_active_o),
      .trip_level_select_o(trip_level_select_o),
      .undervoltage_reset_o(undervoltage_reset_o),
      .stop_legal_o(stop_legal_o),
      .stop_illegal_o(stop_illegal_o),
      .recovery_busy_o(recovery_busy_o),
      .recovery_done_o(recovery_done_o)
   );
   // Clock and hang guard
   initial forever #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i)
      if (++cycles == 20000)
      begin
         miscompares = miscompares + 1;
         tally_and_finish;
      end
   // ********************
   // Tasks
   // ********************
   task chk(input string what, input [18:0] e, input [18:0] g);
      comparisons = comparisons + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task wr(input [15:0] a, input [7:0] v);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_write_i <= 1'b0;
      #1;
   endtask
   task rc(input [15:0] a, input [7:0] e);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_read_i <= 1'b0;
      #1 chk("read", {11'h000, e}, {11'h000, reg_rdata_o});
   endtask
   task rst(input p);
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      por_reset_i <= p;
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      por_reset_i <= 1'b0;
   endtask
   task rec(input uv, input [12:0] e);
      @(posedge clk_sys_i);
      stop_exit_i <= 1'b1;
      stop_exit_uv_i <= uv;
      @(posedge clk_sys_i);
      stop_exit_i <= 1'b0;
      n = 0;
      while (recovery_done_o !== 1'b1 && n < 5000)
      begin
         @(posedge clk_sys_i);
         #1 n = n + 1;
      end
      chk("recovery", {6'h00, e}, n[18:0]);
   endtask
   task tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ********************
   // Main sequence
   // ********************
   initial
   begin
      rows[0] = {`WOR_ADDR_PRIMARY, 8'hff, 8'hff};
      rows[1] = {`WOR_ADDR_PRIMARY, 8'h00, 8'hd7};
      rows[2] = {`WOR_ADDR_PRIMARY, 8'h28, 8'hff};
      rows[3] = {`WOR_ADDR_SECONDARY, 8'hff, 8'hd9};
      rows[4] = {`WOR_ADDR_SECONDARY, 8'h00, 8'hd9};
      rows[5] = {`WOR_ADDR_STATUS, 8'hff, 8'h03};
      rows[6] = {16'h0040, 8'hff, 8'h00};
      rst(1'b1);
      for (i = 0; i < 7; i = i + 1)
      begin
         wr(rows[i][31:16], rows[i][15:8]);
         rc(rows[i][31:16], rows[i][7:0]);
      end
      chk("timeout", `WOR_WDOG_SHORT, watchdog_timeout_o);
      chk("wakeup", {4'h0, `WOR_WAKE_SHORT}, {4'h0, wakeup_period_o});
      chk("pins", 19'h0001a, {13'h0000, irq_pullup_enable_o,
         irq_function_enable_o, reset_pin_function_enable_o,
         watchdog_enable_o, trip_level_select_o,
         monitor_power_enable_o});
      rst(1'b0);
      rc(`WOR_ADDR_PRIMARY, 8'h08);
      rc(`WOR_ADDR_SECONDARY, 8'h01);
      for (i = 0; i < 4; i = i + 1)
      begin
         rst(1'b0);
         wr(`WOR_ADDR_SECONDARY, {3'b000, i[1:0], 3'b000});
         chk("osc", 19'h00001 << i, {15'h0000, osc_ext_xtal_o,
            osc_ext_rc_o, osc_ext_clock_o, osc_internal_o});
      end
      rst(1'b0);
      wr(`WOR_ADDR_PRIMARY, 8'h44);
      chk("stopmon", 19'h00000, {18'h0, monitor_stop_active_o});
      chk("wakeup", {4'h0, `WOR_WAKE_LONG}, {4'h0, wakeup_period_o});
      @(posedge clk_sys_i);
      stop_mode_i <= 1'b1;
      stop_request_i <= 1'b1;
      @(posedge clk_sys_i);
      stop_request_i <= 1'b0;
      #1 chk("illegal", 19'h00001, {18'h00000, stop_illegal_o});
      chk("stopmon", 19'h00001, {18'h0, monitor_stop_active_o});
      rec(1'b0, `WOR_RECOVERY_SHORT);
      rec(1'b1, `WOR_RECOVERY_LONG);
      @(posedge clk_sys_i);
      monitor_trip_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1 chk("uvreset", 19'h00001, {18'h0, undervoltage_reset_o});
      wr(`WOR_ADDR_PRIMARY, 8'h24);
      repeat (4) @(posedge clk_sys_i);
      #1 chk("uvreset", 19'h00000, {18'h0, undervoltage_reset_o});
      chk("timeout", `WOR_WDOG_LONG, watchdog_timeout_o);
      rst(1'b1);
      rc(`WOR_ADDR_PRIMARY, 8'h00);
      rc(`WOR_ADDR_SECONDARY, 8'h00);
      tally_and_finish;
   end
endmodule // tb
